// ### include/flash_pin_pkg.sv
// Shared constants and types for the serial flash pin interface.
package flash_pin_pkg;

    // Serial word width on the link
    localparam int BYTE_BITS = 8;
    // Byte address width of the array
    localparam int ADDR_BITS = 20;
    // Number of uniformly sized protection sectors
    localparam int SECTOR_COUNT = 16;
    // Address bits that pick a sector
    localparam int SECTOR_MSB = 19;
    localparam int SECTOR_LSB = 16;
    localparam int SECTOR_IDX_BITS = SECTOR_MSB - SECTOR_LSB + 1;

    // Bytes between opcode and dual data phase, defaults
    localparam int DUAL_READ_LEAD_DEF = 4;
    localparam int DUAL_PROG_LEAD_DEF = 3;
    // Opcodes that start dual phases (values arbitrary)
    localparam logic [7:0] DUAL_READ_OP_DEF = 8'hC3;
    localparam logic [7:0] DUAL_PROG_OP_DEF = 8'hC5;

    // Sector protection after reset
    localparam logic [SECTOR_COUNT-1:0] PROTECT_RESET = 16'h0000;
    // Bit counter value at a byte boundary
    localparam logic [2:0] BIT_FIRST = 3'h0;

    // Erase granularity levels
    typedef enum logic [1:0] {
        ERASE_4K = 2'h0,
        ERASE_32K = 2'h1,
        ERASE_64K = 2'h2,
        ERASE_CHIP = 2'h3
    } erase_level_e;

    // Link phases within one frame
    typedef enum logic [4:0] {
        PH_CMD = 5'h01,
        PH_LEAD = 5'h02,
        PH_SINGLE = 5'h04,
        PH_DUAL_OUT = 5'h08,
        PH_DUAL_IN = 5'h10
    } link_phase_e;

endpackage

// ### rtl/flash_erase_guard.sv
// Sector coverage check for an erase request against protection bits.
`timescale 1ns/100ps
module flash_erase_guard (
    input wire flash_pin_pkg::erase_level_e level,
    input wire logic [flash_pin_pkg::ADDR_BITS-1:0] addr,
    input wire logic [flash_pin_pkg::SECTOR_COUNT-1:0] sectorProt,
    output logic blocked
);
    import flash_pin_pkg::*;

    // Sectors touched by the requested erase
    logic [SECTOR_COUNT-1:0] covered;
    // Sector picked by the address
    logic [SECTOR_IDX_BITS-1:0] sectorIdx;

    assign sectorIdx = addr[SECTOR_MSB:SECTOR_LSB];

    // Block sizes all lie inside one sector; chip erase covers all
    for (genvar i = 0; i < SECTOR_COUNT; i++) begin : g_cover
        assign covered[i] = (level == ERASE_CHIP) ||
            (sectorIdx == SECTOR_IDX_BITS'(i)); // [R12] [R13]
    end

    // Any protected sector in range refuses the erase
    assign blocked = |(covered & sectorProt); // [R13]

endmodule // flash_erase_guard

// ### rtl/flash_pin_link.sv
// Pin level serial link of a serial flash with dual modes and pause.
//
// What this block does
// R01 - Capture input bits on rising clock
// R02 - Dual read: both pins drive on falling
// R03 - Ignore input pin while deselected
// R04 - Read data changes on falling clock edge
// R05 - Dual program: both pins capture on rising
// R06 - Output pin floats while deselected
// R07 - Write protect locks protection changes
// R08 - Pause ignores clock, floats output, stays selected
// R09 - Pause starts selected with clock low; this block floats both pins as soon as holdN falls, at any clock level
// R10 - Pause never stops internal program cycles
// R11 - Pause pin defaults inactive when open; no pull-up on holdN in this block
// R12 - Four erase granularities including whole chip
// R13 - Equal sectors, each separately protectable
// R14 - Select fall starts, select rise ends
// R15 - Standby waits for internal cycle end
// R16 - Deselect restores normal pin directions
`timescale 1ns/100ps
module flash_pin_link #(
    parameter logic [7:0] DUAL_READ_OP = flash_pin_pkg::DUAL_READ_OP_DEF,
    parameter logic [7:0] DUAL_PROG_OP = flash_pin_pkg::DUAL_PROG_OP_DEF,
    parameter int DUAL_READ_LEAD = flash_pin_pkg::DUAL_READ_LEAD_DEF,
    parameter int DUAL_PROG_LEAD = flash_pin_pkg::DUAL_PROG_LEAD_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic csN,
    input wire logic holdN,
    input wire logic wpN,
    input wire logic siIn,
    output logic siOut,
    output logic siOeN,
    input wire logic soIn,
    output logic soOut,
    output logic soOeN,
    input wire logic busyIn,
    input wire logic txValid,
    input wire logic [flash_pin_pkg::BYTE_BITS-1:0] txData,
    output logic txReady,
    output logic [flash_pin_pkg::BYTE_BITS-1:0] rxByte,
    output logic rxValid,
    output logic frameActive,
    output logic standby,
    output logic hwLocked,
    input wire logic protectSet,
    input wire logic protectClr,
    input wire logic [flash_pin_pkg::SECTOR_IDX_BITS-1:0] protectIdx,
    output logic [flash_pin_pkg::SECTOR_COUNT-1:0] sectorProt,
    input wire flash_pin_pkg::erase_level_e eraseLevel,
    input wire logic [flash_pin_pkg::ADDR_BITS-1:0] eraseAddr,
    output logic eraseBlocked
);
    import flash_pin_pkg::*;

    // Lead counts must fit the 3-bit lead counter and be nonzero
    if (DUAL_READ_LEAD < 1 || DUAL_READ_LEAD > 7 ||
        DUAL_PROG_LEAD < 1 || DUAL_PROG_LEAD > 7) begin : g_bad_lead
        $error("dual lead byte counts must lie in 1..7");
    end

    localparam logic [2:0] READ_LEAD = 3'(DUAL_READ_LEAD);
    localparam logic [2:0] PROG_LEAD = 3'(DUAL_PROG_LEAD);

    // ---------------- Link domain, rising edge ----------------

    // Current frame phase
    link_phase_e phase_r;
    // Phase after this edge
    link_phase_e phase_nxt;
    // Bits taken within the current byte
    logic [2:0] bitCnt_r;
    // Incoming shift register
    logic [7:0] shiftIn_r;
    // Lead bytes still to pass before the dual phase
    logic [2:0] leadCnt_r;
    // Lead phase ends in a dual read (else dual program)
    logic leadIsRead_r;
    // Last complete received byte, stable for a whole byte time
    logic [7:0] rxWord_r;
    // Flips once per received byte
    logic rxTog_r;
    // Bit count after this edge, one spare bit for the wrap
    logic [3:0] bitSum;
    // Shift register after this edge
    logic [7:0] shiftNxt;
    // This edge completes a byte
    logic byteDone;

    // Two bits per edge in dual read and dual program, otherwise one
    always_comb begin
        if (phase_r == PH_DUAL_IN || phase_r == PH_DUAL_OUT) begin
            bitSum = {1'b0, bitCnt_r} + 4'h2; // [R02]
            shiftNxt = {shiftIn_r[5:0], soIn, siIn}; // [R05]
        end else begin
            bitSum = {1'b0, bitCnt_r} + 4'h1;
            shiftNxt = {shiftIn_r[6:0], siIn}; // [R01]
        end
        byteDone = bitSum[3];
    end

    // Phase walk at byte boundaries
    always_comb begin
        phase_nxt = phase_r;
        unique case (phase_r)
            PH_CMD: begin
                if (shiftNxt == DUAL_READ_OP || shiftNxt == DUAL_PROG_OP) begin
                    phase_nxt = PH_LEAD;
                end else begin
                    phase_nxt = PH_SINGLE;
                end
            end
            PH_LEAD: begin
                if (leadCnt_r == 3'h1) begin
                    phase_nxt = leadIsRead_r ? PH_DUAL_OUT : PH_DUAL_IN;
                end
            end
            PH_SINGLE, PH_DUAL_OUT, PH_DUAL_IN: begin
                phase_nxt = phase_r;
            end
        endcase
    end

    // Capture on rising clock; select high clears the frame
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            phase_r <= PH_CMD; // [R14] [R16]
            bitCnt_r <= BIT_FIRST;
            shiftIn_r <= 8'h00;
            leadCnt_r <= 3'h0;
            leadIsRead_r <= 1'b0;
        end else if (holdN) begin // [R08] [R11]
            bitCnt_r <= bitSum[2:0]; // [R01]
            shiftIn_r <= shiftNxt;
            if (byteDone) begin
                phase_r <= phase_nxt; // [R02] [R05]
                if (phase_r == PH_CMD) begin
                    leadIsRead_r <= (shiftNxt == DUAL_READ_OP);
                    leadCnt_r <= (shiftNxt == DUAL_READ_OP) ? READ_LEAD : PROG_LEAD;
                end else if (phase_r == PH_LEAD) begin
                    leadCnt_r <= leadCnt_r - 3'h1;
                end
            end
        end
    end

    // Received byte and its event toggle; kept across frames
    always_ff @(posedge sck or posedge sys_rst) begin
        if (sys_rst) begin
            rxWord_r <= 8'h00;
            rxTog_r <= 1'b0;
        end else if (!csN && holdN && byteDone) begin // [R03] [R08]
            rxWord_r <= shiftNxt;
            rxTog_r <= ~rxTog_r;
        end
    end

    // ---------------- Link domain, falling edge ----------------

    // Request level from the core, two-stage synchroniser
    logic txReqS1_r;
    logic txReqS2_r;
    // Acknowledge level back to the core
    logic txAck_r;
    // Byte currently on the wire
    logic [7:0] txCur_r;
    // Falling edge that starts a new output byte
    logic loadNow;
    // A fresh core byte is waiting
    logic fresh;
    // Byte chosen at a load
    logic [7:0] loadByte;
    // Driving phases
    logic outSingle;
    logic outDual;
    // Transmit holding register and request level, system clock side
    logic [7:0] txBuf_r;
    logic txReq_r;

    assign outSingle = (phase_r == PH_SINGLE);
    assign outDual = (phase_r == PH_DUAL_OUT);
    assign loadNow = (outSingle || outDual) && (bitCnt_r == BIT_FIRST);
    assign fresh = txReqS2_r && !txAck_r;
    assign loadByte = fresh ? txBuf_r : txCur_r;

    // Request synchroniser and four-phase acknowledge
    always_ff @(negedge sck or posedge sys_rst) begin
        if (sys_rst) begin
            txReqS1_r <= 1'b0;
            txReqS2_r <= 1'b0;
            txAck_r <= 1'b0;
            txCur_r <= 8'hFF;
        end else begin
            txReqS1_r <= txReq_r;
            txReqS2_r <= txReqS1_r;
            if (!csN && holdN && loadNow) begin
                txCur_r <= loadByte;
                if (fresh) begin
                    txAck_r <= 1'b1;
                end
            end else if (!txReqS2_r) begin
                txAck_r <= 1'b0;
            end
        end
    end

    // Data pins change on falling clock; select high clears them
    always_ff @(negedge sck or posedge csN) begin
        if (csN) begin
            soOut <= 1'b0;
            siOut <= 1'b0;
        end else if (holdN) begin // [R08]
            if (loadNow) begin
                soOut <= loadByte[7]; // [R04]
                siOut <= loadByte[6]; // [R02]
            end else begin
                soOut <= txCur_r[3'h7 - bitCnt_r]; // [R04]
                siOut <= txCur_r[3'h6 - bitCnt_r];
            end
        end
    end

    // Pin directions; deselect or pause floats both at once
    always_ff @(negedge sck or posedge csN or negedge holdN) begin
        if (csN) begin
            soOeN <= 1'b1; // [R06] [R16]
            siOeN <= 1'b1; // [R16]
        end else if (!holdN) begin
            soOeN <= 1'b1; // [R08] [R09]
            siOeN <= 1'b1;
        end else begin
            soOeN <= !(outSingle || outDual); // [R04]
            siOeN <= !outDual; // [R02]
        end
    end

    // ---------------- System clock domain ----------------

    // Pin synchronisers
    logic csS1_r;
    logic csS2_r;
    logic wpS1_r;
    logic wpS2_r;
    // Received byte toggle, two stages plus edge reference
    logic rxS1_r;
    logic rxS2_r;
    logic rxS3_r;
    // Acknowledge synchroniser
    logic ackS1_r;
    logic ackS2_r;
    // Erase check result
    logic guardBlocked;

    // Pin levels into the system clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            csS1_r <= 1'b1;
            csS2_r <= 1'b1;
            wpS1_r <= 1'b1;
            wpS2_r <= 1'b1;
        end else begin
            csS1_r <= csN;
            csS2_r <= csS1_r;
            wpS1_r <= wpN;
            wpS2_r <= wpS1_r;
        end
    end

    // Frame and standby status
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frameActive <= 1'b0;
            standby <= 1'b1;
        end else begin
            frameActive <= !csS2_r; // [R14]
            // Pause never reaches here, so busy cycles run on
            standby <= csS2_r && !busyIn; // [R15] [R10]
        end
    end

    // Received byte event into the system clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxS1_r <= 1'b0;
            rxS2_r <= 1'b0;
            rxS3_r <= 1'b0;
            rxValid <= 1'b0;
            rxByte <= 8'h00;
        end else begin
            rxS1_r <= rxTog_r;
            rxS2_r <= rxS1_r;
            rxS3_r <= rxS2_r;
            rxValid <= rxS2_r ^ rxS3_r;
            if (rxS2_r ^ rxS3_r) begin
                rxByte <= rxWord_r;
            end
        end
    end

    // Transmit handshake: buffer holds still while request is up
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ackS1_r <= 1'b0;
            ackS2_r <= 1'b0;
            txReq_r <= 1'b0;
            txBuf_r <= 8'hFF;
            txReady <= 1'b0;
        end else begin
            ackS1_r <= txAck_r;
            ackS2_r <= ackS1_r;
            if (!txReq_r && !ackS2_r && txReady && txValid) begin
                txBuf_r <= txData;
                txReq_r <= 1'b1;
                txReady <= 1'b0;
            end else if (txReq_r && ackS2_r) begin
                txReq_r <= 1'b0;
                txReady <= 1'b0;
            end else begin
                txReady <= !txReq_r && !ackS2_r;
            end
        end
    end

    // Protection bits, frozen while write protect is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hwLocked <= 1'b0;
            sectorProt <= PROTECT_RESET;
        end else begin
            hwLocked <= !wpS2_r; // [R07]
            if (wpS2_r) begin // [R07]
                if (protectSet) begin
                    sectorProt[protectIdx] <= 1'b1; // [R13]
                end else if (protectClr) begin
                    sectorProt[protectIdx] <= 1'b0; // [R13]
                end
            end
        end
    end

    // Erase coverage check
    flash_erase_guard u_guard (
        .level(eraseLevel),
        .addr(eraseAddr),
        .sectorProt(sectorProt),
        .blocked(guardBlocked)
    );

    // Registered erase refusal
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eraseBlocked <= 1'b0;
        end else begin
            eraseBlocked <= guardBlocked; // [R12]
        end
    end

endmodule // flash_pin_link

// ### testbench/flash_pin_link_asserts.sv
// Concurrent checks on the pin link ports.
`timescale 1ns/100ps
module flash_pin_link_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic csN,
    input wire logic holdN,
    input wire logic wpN,
    input wire logic busyIn,
    input wire logic siOut,
    input wire logic siOeN,
    input wire logic soOut,
    input wire logic soOeN,
    input wire logic frameActive,
    input wire logic standby,
    input wire logic hwLocked,
    input wire logic [flash_pin_pkg::SECTOR_COUNT-1:0] sectorProt,
    input wire flash_pin_pkg::erase_level_e eraseLevel,
    input wire logic [flash_pin_pkg::ADDR_BITS-1:0] eraseAddr,
    input wire logic eraseBlocked
);
    import flash_pin_pkg::*;
    // Pin data held at the last rising link edge
    logic [1:0] pinsAtRise;
    // Snapshot taken where nothing may change
    always_ff @(posedge sck) begin
        pinsAtRise <= {soOut, siOut};
    end
    a_so_desel_float: assert property (@(posedge clk) disable iff (sys_rst)
        csN |-> soOeN) else $error("output pin driven while deselected");
    a_dirs_restored: assert property (@(posedge clk) disable iff (sys_rst)
        csN |-> siOeN) else $error("input pin driven while deselected");
    a_pause_floats: assert property (@(posedge clk) disable iff (sys_rst)
        !holdN |-> soOeN && siOeN) else $error("pin driven during pause");
    a_launch_falling: assert property (@(negedge sck) disable iff (csN || !holdN)
        {soOut, siOut} == pinsAtRise) else $error("pin data moved on rising edge");
    a_frame_track: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(csN) |-> ##[1:4] (frameActive == !csN)) else $error("frame state lags");
    a_standby_busy: assert property (@(posedge clk) disable iff (sys_rst)
        busyIn ##1 busyIn |-> !standby) else $error("standby during busy");
    a_lock_follow: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(wpN) |-> ##[1:4] hwLocked) else $error("lock not taken");
    a_prot_frozen: assert property (@(posedge clk) disable iff (sys_rst)
        hwLocked [*3] |-> $stable(sectorProt)) else $error("protection changed while locked");
    a_erase_chip: assert property (@(posedge clk) disable iff (sys_rst)
        eraseLevel == ERASE_CHIP |=> eraseBlocked == (|$past(sectorProt)))
        else $error("chip erase guard wrong");
    a_erase_sector: assert property (@(posedge clk) disable iff (sys_rst)
        eraseLevel != ERASE_CHIP |=>
        eraseBlocked == $past(sectorProt[eraseAddr[SECTOR_MSB:SECTOR_LSB]]))
        else $error("sector erase guard wrong");
    // Main scenarios reached
    c_frame: cover property (@(posedge clk) $fell(csN));
    c_pause: cover property (@(posedge clk) !csN && $fell(holdN));
    c_dual: cover property (@(posedge clk) !siOeN);
endmodule // flash_pin_link_asserts
bind flash_pin_link flash_pin_link_asserts chk_u (.clk(clk), .sys_rst(sys_rst),
    .sck(sck), .csN(csN), .holdN(holdN), .wpN(wpN), .busyIn(busyIn), .siOut(siOut),
    .siOeN(siOeN), .soOut(soOut), .soOeN(soOeN), .frameActive(frameActive),
    .standby(standby), .hwLocked(hwLocked), .sectorProt(sectorProt),
    .eraseLevel(eraseLevel), .eraseAddr(eraseAddr), .eraseBlocked(eraseBlocked));

// ### testbench/spi_host_model.sv
// Host controller model: select, link clock, data and pause.
`timescale 1ns/100ps
module spi_host_model (
    output logic sck,
    output logic csN,
    output logic holdN,
    output logic hostSi,
    output logic hostSo,
    input wire logic siIn,
    input wire logic soIn
);
    // Idle: deselected, clock parked low
    initial begin
        sck = 1'b0;
        holdN = 1'b1;
        hostSi = 1'b0;
        hostSo = 1'b0;
        // Late select edge so the pin flops see a real deselect
        #1 csN = 1'b1;
    end
    // Frame edge with clock low
    task automatic sel(input logic on);
        #24 csN = !on;
        #24;
    endtask
    // One byte; mode 1 dual out, 2 dual in; pause before bit pz
    task automatic xfer(input logic [7:0] tx, input int mode, input int pz,
                        output logic [7:0] rx);
        for (int i = 7; i >= 0; i -= ((mode != 0) ? 2 : 1)) begin
            // Pause only while selected and clock low
            if (i == pz) begin
                #4 holdN = 1'b0;
                hostSi = !tx[i];
                #24 sck = 1'b1;
                #24 sck = 1'b0;
                #100 holdN = 1'b1;
            end
            // Released lines flip; dual in drives both
            hostSi = (mode == 1) ? !hostSi : ((mode == 2) ? tx[i-1] : tx[i]);
            hostSo = (mode == 2) ? tx[i] : !hostSo;
            #24 sck = 1'b1;
            rx[i] = soIn;
            // Dual out: lower bit on the input pin
            if (mode == 1) begin
                rx[i-1] = siIn;
            end
            #24 sck = 1'b0;
        end
    endtask
endmodule // spi_host_model

// ### testbench/serial_flash_pin_interface_tb_top.sv
// Self-checking bench for the pin link.
`timescale 1ns/100ps
module serial_flash_pin_interface_tb_top;
    import flash_pin_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b0, wpN = 1'b1, busyIn = 1'b0, txValid = 1'b0;
    logic protectSet = 1'b0, protectClr = 1'b0;
    logic [3:0] protectIdx = 4'h0;
    logic [7:0] txData = 8'h00, rxByte, rx;
    erase_level_e eraseLevel = ERASE_4K;
    logic [19:0] eraseAddr = 20'h00000;
    logic sck, csN, holdN, hostSi, hostSo, siIn, soIn, siOut, siOeN, soOut, soOeN;
    logic txReady, rxValid, frameActive, standby, hwLocked, eraseBlocked;
    logic [15:0] sectorProt;
    logic [7:0] rxQ[$];
    int miscompares = 0, checked = 0;
    // System clock
    always #25 clk = !clk;
    // Wire levels from the link's output enables
    assign siIn = siOeN ? hostSi : siOut;
    assign soIn = soOeN ? hostSo : soOut;
    flash_pin_link dut_u (.clk(clk), .sys_rst(sys_rst), .sck(sck), .csN(csN),
        .holdN(holdN), .wpN(wpN), .siIn(siIn), .siOut(siOut), .siOeN(siOeN),
        .soIn(soIn), .soOut(soOut), .soOeN(soOeN), .busyIn(busyIn), .txValid(txValid),
        .txData(txData), .txReady(txReady), .rxByte(rxByte), .rxValid(rxValid),
        .frameActive(frameActive), .standby(standby), .hwLocked(hwLocked),
        .protectSet(protectSet), .protectClr(protectClr), .protectIdx(protectIdx),
        .sectorProt(sectorProt), .eraseLevel(eraseLevel), .eraseAddr(eraseAddr),
        .eraseBlocked(eraseBlocked));
    spi_host_model host_u (.sck(sck), .csN(csN), .holdN(holdN), .hostSi(hostSi),
        .hostSo(hostSo), .siIn(siIn), .soIn(soIn));
    // Collect received bytes
    always @(negedge clk) begin
        if (rxValid === 1'b1) rxQ.push_back(rxByte);
    end
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // Offer one read byte, held until taken
    task automatic offer(input logic [7:0] b);
        @(negedge clk);
        txValid = 1'b1;
        txData = b;
        @(posedge clk);
        while (txReady !== 1'b1) @(posedge clk);
        @(negedge clk);
        txValid = 1'b0;
    endtask
    // Close a frame and let crossings settle
    task automatic done();
        host_u.sel(1'b0);
        repeat (5) @(posedge clk);
    endtask
    task automatic t_single();
        offer(8'h6B);
        rxQ.delete();
        host_u.sel(1'b1);
        host_u.xfer(8'h03, 0, -1, rx);
        host_u.xfer(8'h00, 0, -1, rx);
        chk(rx, 8'h6B);
        done();
        chk(rxQ[0], 8'h03);
        chk({frameActive, soOeN}, 2'h1);
        $display("single done");
    endtask
    task automatic t_dual_rd();
        offer(8'h96);
        host_u.sel(1'b1);
        host_u.xfer(8'hC3, 0, -1, rx);
        for (int k = 0; k < 4; k++) host_u.xfer(8'h00, 0, -1, rx);
        host_u.xfer(8'h00, 1, -1, rx);
        chk(rx, 8'h96);
        chk({siOeN, soOeN}, 2'h0);
        done();
        chk({siOeN, soOeN}, 2'h3);
        $display("dual read done");
    endtask
    task automatic t_dual_pg();
        rxQ.delete();
        host_u.sel(1'b1);
        host_u.xfer(8'hC5, 0, -1, rx);
        for (int k = 0; k < 3; k++) host_u.xfer(8'h5E, 0, -1, rx);
        host_u.xfer(8'hA7, 2, -1, rx);
        chk(soOeN, 1'b1);
        done();
        chk(rxQ[4], 8'hA7);
        chk(rxQ.size(), 5);
        $display("dual program done");
    endtask
    task automatic t_pause();
        rxQ.delete();
        @(negedge clk) busyIn = 1'b1;
        host_u.sel(1'b1);
        host_u.xfer(8'h3C, 0, 4, rx);
        host_u.xfer(8'h00, 0, 2, rx);
        chk(frameActive, 1'b1);
        done();
        chk(rxQ[0], 8'h3C);
        chk(standby, 1'b0);
        @(negedge clk) busyIn = 1'b0;
        repeat (4) @(posedge clk);
        chk(standby, 1'b1);
        $display("pause done");
    endtask
    // Set or clear one sector bit
    task automatic prot(input logic set);
        @(negedge clk);
        protectSet = set;
        protectClr = !set;
        protectIdx = 4'h3;
        @(negedge clk);
        protectSet = 1'b0;
        protectClr = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // Erase query against expectation
    task automatic eq(input erase_level_e lv, input logic [19:0] a, input logic exp);
        @(negedge clk);
        eraseLevel = lv;
        eraseAddr = a;
        repeat (2) @(negedge clk);
        chk(eraseBlocked, exp);
    endtask
    task automatic t_protect();
        prot(1'b1);
        chk(sectorProt, 16'h0008);
        eq(ERASE_4K, 20'h3F000, 1'b1);
        eq(ERASE_32K, 20'h28000, 1'b0);
        eq(ERASE_64K, 20'h40000, 1'b0);
        eq(ERASE_CHIP, 20'h00000, 1'b1);
        @(negedge clk) wpN = 1'b0;
        repeat (5) @(negedge clk);
        chk(hwLocked, 1'b1);
        prot(1'b0);
        chk(sectorProt, 16'h0008);
        @(negedge clk) wpN = 1'b1;
        repeat (5) @(negedge clk);
        prot(1'b0);
        chk(sectorProt, 16'h0000);
        $display("protect done");
    endtask
    // Verdict and end of run
    task automatic wrap_up();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Reset, then the scenarios
    initial begin
        // Rising reset edge also clears the link side receive toggle and transmit handshake flops
        #1 sys_rst = 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk) sys_rst = 1'b0;
        repeat (3) @(posedge clk);
        t_single();
        t_dual_rd();
        t_dual_pg();
        t_pause();
        t_protect();
        wrap_up();
    end
    // Watchdog well past the expected run
    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end
endmodule // serial_flash_pin_interface_tb_top
